// File: common/program_data_space_access_pkg.sv
// Overview of operation
// RL1: Program words 24 bits, addresses step by two
// RL2: Word table_read_low returns program bits 15:0
// RL3: Byte table_read_low picks low or middle byte
// RL4: Word table_read_high returns bits 23:16, upper zero
// RL5: Byte table_read_high: bits 23:16 or zero byte
// RL6: Upper program byte reached only by high ops
// RL7: Window redirect needs address MSB and enable
// RL8: Upper 32 Kbytes map onto one program page
// RL9: Window address: page register plus low 15 bits
// RL10: Window read returns low 16 program bits
// RL11: Window mapping suspended during table operations
// RL12: Window outside repeat adds one or two cycles
// RL13: Window inside repeat adds two at loop edges
// RL14: Y region fixed, contiguous, inside X region
// RL15: Other instructions see one linear X space
// RL16: Dual reads use pointers eight/nine and ten/eleven
// RL17: All writes on X bus, Y only reads
// RL18: Accumulator write-back reaches whole data space via X
// RL19: Modulo both regions, bit-reverse only X writes
// RL20: Invalid or wrong-region reads return zero
// RL21: Effective addresses 16 bits, byte granular
// RL22: Table page MSB selects user or configuration
// RL23: Byte select is effective address bit zero
// RL24: Window read uses two sequential program fetches
package program_data_space_access_pkg;
   // ==========================================================
   // Widths
   localparam int unsigned PM_ADDR_W = 24;
   localparam int unsigned PM_WORD_W = 24;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned EA_W = 16;
   localparam int unsigned PAGE_W = 8;
   localparam int unsigned WIN_OFS_W = 15;
   localparam int unsigned EA_MSB = 15;
   localparam int unsigned TBL_CFG_BIT = 7;
   // ==========================================================
   // Data space regions
   localparam logic [15:0] IMPL_LAST = 16'h1FFF;
   localparam logic [15:0] Y_FIRST = 16'h1000;
   localparam logic [15:0] Y_LAST = 16'h1FFF;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // ==========================================================
   // Extra cycle counts
   localparam logic [1:0] EXTRA_NONE = 2'h0;
   localparam logic [1:0] EXTRA_ONE = 2'h1;
   localparam logic [1:0] EXTRA_TWO = 2'h2;
   // ==========================================================
   // Byte enables
   localparam logic [1:0] BE_NONE = 2'h0;
   localparam logic [1:0] BE_LOW = 2'h1;
   localparam logic [1:0] BE_HIGH = 2'h2;
   localparam logic [2:0] PBE_NONE = 3'h0;
   localparam logic [2:0] PBE_B0 = 3'h1;
   localparam logic [2:0] PBE_B1 = 3'h2;
   localparam logic [2:0] PBE_LOW_WORD = 3'h3;
   localparam logic [2:0] PBE_B2 = 3'h4;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      OP_DATA_RD = 3'b000,
      OP_DATA_WR = 3'b001,
      OP_TBL_RD_LO = 3'b010,
      OP_TBL_RD_HI = 3'b011,
      OP_TBL_WR_LO = 3'b100,
      OP_TBL_WR_HI = 3'b101,
      OP_DUAL_RD = 3'b110
   } op_t;
   typedef enum logic [1:0] {
      CLS_MULACC_PREFETCH = 2'b00,
      CLS_MOVE = 2'b01,
      CLS_DOUBLE_MOVE = 2'b10,
      CLS_OTHER = 2'b11
   } instr_cls_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RD = 3'b001,
      ST_PW1 = 3'b010,
      ST_PW2 = 3'b011,
      ST_CAP = 3'b100,
      ST_WR = 3'b101
   } state_t;
endpackage

// File: design/program_data_space_access.sv
`timescale 1ns/100ps
module program_data_space_access
   import program_data_space_access_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic req_valid,
   output logic req_ready,
   input wire op_t req_op,
   input wire logic req_byte,
   input wire logic [15:0] req_ea,
   input wire logic [15:0] req_wdata,
   input wire logic req_bitrev,
   input wire logic req_modulo,
   input wire logic x_ptr_sel,
   input wire logic y_ptr_sel,
   input wire logic [15:0] x_pointer_a,
   input wire logic [15:0] x_pointer_b,
   input wire logic [15:0] y_pointer_a,
   input wire logic [15:0] y_pointer_b,
   input wire instr_cls_t req_cls,
   input wire logic in_repeat,
   input wire logic repeat_first,
   input wire logic repeat_last,
   input wire logic repeat_int_exit,
   input wire logic repeat_reentry,
   input wire logic program_window_enable,
   input wire logic [7:0] program_window_page,
   input wire logic [7:0] table_page_reg,
   output logic [23:0] pm_addr,
   output logic pm_rd,
   output logic pm_wr,
   output logic [2:0] pm_be,
   output logic [23:0] pm_wdata,
   output logic pm_config_space,
   input wire logic [23:0] pm_rdata,
   output logic [15:0] xmem_addr,
   output logic xmem_rd,
   output logic xmem_wr,
   output logic [1:0] xmem_be,
   output logic [15:0] xmem_wdata,
   input wire logic [15:0] xmem_rdata,
   output logic [15:0] ymem_addr,
   output logic ymem_rd,
   input wire logic [15:0] ymem_rdata,
   output logic rsp_valid,
   output logic [15:0] x_rdata,
   output logic [15:0] y_rdata,
   output logic [1:0] extra_cycles,
   output logic bitrev_ok,
   output logic modulo_ok
);
   // ==========================================================
   // Registers
   state_t st_ff, nxt_st;
   op_t op_ff;
   logic byte_ff, sel_ff, win_ff, x_inv_ff, y_inv_ff, rsp_ff;
   logic [23:0] pm_addr_ff, pm_wdata_ff;
   logic pm_rd_ff, pm_wr_ff, cfg_ff;
   logic [2:0] pm_be_ff;
   logic [15:0] xa_ff, xwd_ff, ya_ff, xrd_ff, yrd_ff;
   logic xr_ff, xw_ff, yr_ff, brev_ff, mod_ff;
   logic [1:0] xbe_ff, extra_ff;

   // ==========================================================
   // Request decode
   wire accept = req_valid && (st_ff == ST_IDLE);
   wire is_dual = (req_op == OP_DUAL_RD);
   wire is_tbl = (req_op == OP_TBL_RD_LO) || (req_op == OP_TBL_RD_HI) ||
      (req_op == OP_TBL_WR_LO) || (req_op == OP_TBL_WR_HI);
   wire is_wr = (req_op == OP_DATA_WR) || (req_op == OP_TBL_WR_LO) ||
      (req_op == OP_TBL_WR_HI);
   wire sel = req_ea[0]; // [RL23]
   wire [15:0] x_ea = is_dual ? (x_ptr_sel ? x_pointer_b : x_pointer_a) : req_ea; // [RL16]
   wire [15:0] y_ea = y_ptr_sel ? y_pointer_b : y_pointer_a; // [RL16]
   // Table operations never take the window path
   wire win_hit = x_ea[EA_MSB] && program_window_enable &&
      ((req_op == OP_DATA_RD) || is_dual); // [RL7] [RL11]
   wire x_in_y = (x_ea >= Y_FIRST) && (x_ea <= Y_LAST); // [RL14]
   wire y_in_y = (y_ea >= Y_FIRST) && (y_ea <= Y_LAST); // [RL14]
   wire x_impl = (x_ea <= IMPL_LAST); // [RL21]
   // Linear space for all but dual reads; dual X pointers skip Y
   wire x_inv = !win_hit && (!x_impl || (is_dual && x_in_y)); // [RL15] [RL20]
   wire y_inv = is_dual && !y_in_y; // [RL20]
   wire [23:0] tbl_addr = {table_page_reg, req_ea}; // [RL1] [RL22]
   wire [23:0] win_addr = {1'b0, program_window_page, x_ea[WIN_OFS_W-1:0]}; // [RL8] [RL9]
   wire rep_edge = repeat_first || repeat_last || repeat_int_exit || repeat_reentry;
   wire light = (req_cls != CLS_OTHER);
   wire [1:0] extra = !win_hit ? EXTRA_NONE :
      in_repeat ? (rep_edge ? EXTRA_TWO : EXTRA_NONE) : // [RL13]
      (light ? EXTRA_ONE : EXTRA_TWO); // [RL12]

   // ==========================================================
   // Write data and lanes
   wire [7:0] wbyte = req_wdata[7:0];
   wire [1:0] dbe = req_byte ? (sel ? BE_HIGH : BE_LOW) : (BE_HIGH | BE_LOW);
   wire [15:0] dwd = req_byte ? {wbyte, wbyte} : req_wdata;
   wire [2:0] pbe_lo = req_byte ? (sel ? PBE_B1 : PBE_B0) : PBE_LOW_WORD;
   wire [2:0] pbe_hi = (req_byte && sel) ? PBE_NONE : PBE_B2; // [RL5] [RL6]
   wire [2:0] pbe = (req_op == OP_TBL_WR_HI) ? pbe_hi : pbe_lo;
   wire [23:0] pwd = (req_op == OP_TBL_WR_HI) ? {wbyte, ZERO_WORD} :
      (req_byte ? {ZERO_BYTE, wbyte, wbyte} : {ZERO_BYTE, req_wdata});
   wire wr_ok = (req_op == OP_DATA_WR) ? (req_ea <= IMPL_LAST) : 1'b1;

   // ==========================================================
   // Read data shaping
   wire [15:0] pm_lo = pm_rdata[15:0]; // [RL10]
   wire [7:0] pm_hi = pm_rdata[23:16];
   wire [15:0] xw = win_ff ? pm_lo : xmem_rdata;
   wire [15:0] xw_b = sel_ff ? {ZERO_BYTE, xw[15:8]} : {ZERO_BYTE, xw[7:0]};
   wire [15:0] tlo_b = sel_ff ? {ZERO_BYTE, pm_lo[15:8]} : {ZERO_BYTE, pm_lo[7:0]}; // [RL3]
   wire [15:0] thi = {ZERO_BYTE, pm_hi}; // [RL4]
   wire [15:0] thi_b = sel_ff ? ZERO_WORD : thi; // [RL5]
   wire [15:0] x_res = (op_ff == OP_TBL_RD_LO) ? (byte_ff ? tlo_b : pm_lo) : // [RL2]
      (op_ff == OP_TBL_RD_HI) ? (byte_ff ? thi_b : thi) : // [RL6]
      x_inv_ff ? ZERO_WORD : // [RL20]
      ((byte_ff && (op_ff != OP_DUAL_RD)) ? xw_b : xw);
   wire [15:0] y_res = y_inv_ff ? ZERO_WORD : ymem_rdata; // [RL20]

   // ==========================================================
   // Sequencer
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE: begin
            if (accept) begin
               if (is_wr) begin
                  nxt_st = ST_WR;
               end else if (win_hit) begin
                  nxt_st = ST_PW1; // [RL24]
               end else begin
                  nxt_st = ST_RD;
               end
            end
         end
         ST_RD: nxt_st = ST_CAP;
         ST_PW1: nxt_st = ST_PW2;
         ST_PW2: nxt_st = ST_CAP;
         ST_CAP: nxt_st = ST_IDLE;
         ST_WR: nxt_st = ST_IDLE;
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_ff <= ST_IDLE;
         rsp_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         rsp_ff <= (st_ff == ST_CAP) || (st_ff == ST_WR);
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         op_ff <= OP_DATA_RD;
         byte_ff <= 1'b0;
         sel_ff <= 1'b0;
         win_ff <= 1'b0;
         x_inv_ff <= 1'b0;
         y_inv_ff <= 1'b0;
         extra_ff <= EXTRA_NONE;
         brev_ff <= 1'b0;
         mod_ff <= 1'b0;
         cfg_ff <= 1'b0;
      end else if (accept) begin
         op_ff <= req_op;
         byte_ff <= req_byte;
         sel_ff <= sel;
         win_ff <= win_hit;
         x_inv_ff <= x_inv;
         y_inv_ff <= y_inv;
         extra_ff <= extra;
         brev_ff <= req_bitrev && (req_op == OP_DATA_WR); // [RL19]
         mod_ff <= req_modulo; // [RL19]
         cfg_ff <= is_tbl && table_page_reg[TBL_CFG_BIT]; // [RL22]
      end
   end

   // ==========================================================
   // Program memory port
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pm_addr_ff <= 24'h00_0000;
         pm_rd_ff <= 1'b0;
         pm_wr_ff <= 1'b0;
         pm_be_ff <= PBE_NONE;
         pm_wdata_ff <= 24'h00_0000;
      end else if (accept) begin
         pm_addr_ff <= win_hit ? win_addr : tbl_addr;
         pm_rd_ff <= win_hit || (req_op == OP_TBL_RD_LO) || (req_op == OP_TBL_RD_HI);
         pm_wr_ff <= (req_op == OP_TBL_WR_LO) || (req_op == OP_TBL_WR_HI);
         pm_be_ff <= pbe;
         pm_wdata_ff <= pwd;
      end else begin
         pm_rd_ff <= (st_ff == ST_PW1); // [RL24]
         pm_wr_ff <= 1'b0;
      end
   end

   // ==========================================================
   // Data memory ports
   always_ff @(posedge clk) begin
      if (!rstn) begin
         xa_ff <= ZERO_WORD;
         xr_ff <= 1'b0;
         xw_ff <= 1'b0;
         xbe_ff <= BE_NONE;
         xwd_ff <= ZERO_WORD;
         ya_ff <= ZERO_WORD;
         yr_ff <= 1'b0;
      end else if (accept) begin
         xa_ff <= x_ea;
         xr_ff <= ((req_op == OP_DATA_RD) || is_dual) && !x_inv && !win_hit;
         xw_ff <= (req_op == OP_DATA_WR) && wr_ok; // [RL17] [RL18]
         xbe_ff <= dbe;
         xwd_ff <= dwd;
         ya_ff <= y_ea;
         yr_ff <= is_dual && !y_inv && !win_hit; // [RL16]
      end else begin
         xr_ff <= 1'b0;
         xw_ff <= 1'b0;
         // Window dual reads fetch Y late so its data meets the capture cycle
         yr_ff <= (st_ff == ST_PW1) && (op_ff == OP_DUAL_RD) && !y_inv_ff; // [RL16]
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         xrd_ff <= ZERO_WORD;
         yrd_ff <= ZERO_WORD;
      end else if (st_ff == ST_CAP) begin
         xrd_ff <= x_res;
         yrd_ff <= (op_ff == OP_DUAL_RD) ? y_res : ZERO_WORD;
      end
   end

   // ==========================================================
   // Outputs
   assign req_ready = (st_ff == ST_IDLE);
   assign pm_addr = pm_addr_ff;
   assign pm_rd = pm_rd_ff;
   assign pm_wr = pm_wr_ff;
   assign pm_be = pm_be_ff;
   assign pm_wdata = pm_wdata_ff;
   assign pm_config_space = cfg_ff;
   assign xmem_addr = xa_ff;
   assign xmem_rd = xr_ff;
   assign xmem_wr = xw_ff;
   assign xmem_be = xbe_ff;
   assign xmem_wdata = xwd_ff;
   assign ymem_addr = ya_ff;
   assign ymem_rd = yr_ff;
   assign rsp_valid = rsp_ff;
   assign x_rdata = xrd_ff;
   assign y_rdata = yrd_ff;
   assign extra_cycles = extra_ff;
   assign bitrev_ok = brev_ff;
   assign modulo_ok = mod_ff;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   wire cap_tlo_w = (st_ff == ST_CAP) && (op_ff == OP_TBL_RD_LO) && !byte_ff;
   wire cap_tlo_b = (st_ff == ST_CAP) && (op_ff == OP_TBL_RD_LO) && byte_ff;
   wire cap_thi = (st_ff == ST_CAP) && (op_ff == OP_TBL_RD_HI);

   property p_tbl_lo_word;
      cap_tlo_w |=> x_rdata == $past(pm_lo);
   endproperty
   a_tbl_lo_word: assert property (p_tbl_lo_word) else $error("low word wrong"); // [RL2]

   property p_tbl_lo_byte;
      cap_tlo_b |=> x_rdata == $past(tlo_b) && x_rdata[15:8] == ZERO_BYTE;
   endproperty
   a_tbl_lo_byte: assert property (p_tbl_lo_byte) else $error("low byte wrong"); // [RL3]

   property p_tbl_hi;
      cap_thi && !(byte_ff && sel_ff) |=> x_rdata == {ZERO_BYTE, $past(pm_hi)};
   endproperty
   a_tbl_hi: assert property (p_tbl_hi) else $error("high read wrong"); // [RL4]

   property p_tbl_hi_phantom;
      cap_thi && byte_ff && sel_ff |=> x_rdata == ZERO_WORD;
   endproperty
   a_tbl_hi_phantom: assert property (p_tbl_hi_phantom) else $error("phantom byte"); // [RL5]

   property p_win_addr;
      accept && win_hit |=> pm_addr == $past(win_addr) && pm_addr[23] == 1'b0;
   endproperty
   a_win_addr: assert property (p_win_addr) else $error("window address wrong"); // [RL9]

   property p_win_two_fetch;
      accept && win_hit |=> pm_rd [*2] ##1 !pm_rd ##1 rsp_valid;
   endproperty
   a_win_two_fetch: assert property (p_win_two_fetch) else $error("fetch count"); // [RL24]

   property p_tbl_addr;
      accept && is_tbl |=> pm_addr == $past(tbl_addr) && st_ff != ST_PW1;
   endproperty
   a_tbl_addr: assert property (p_tbl_addr) else $error("table address"); // [RL11]

   property p_extra_out;
      accept && win_hit && !in_repeat |=> extra_cycles == ($past(light) ? EXTRA_ONE : EXTRA_TWO);
   endproperty
   a_extra_out: assert property (p_extra_out) else $error("extra outside"); // [RL12]

   property p_extra_rep;
      accept && win_hit && in_repeat && !rep_edge |=> extra_cycles == EXTRA_NONE;
   endproperty
   a_extra_rep: assert property (p_extra_rep) else $error("extra inside"); // [RL13]

   property p_wr_x;
      accept && (req_op == OP_DATA_WR) && wr_ok |=> xmem_wr && !ymem_rd ##1 rsp_valid;
   endproperty
   a_wr_x: assert property (p_wr_x) else $error("write path"); // [RL17]

   property p_inv_zero;
      (st_ff == ST_CAP) && x_inv_ff && (op_ff == OP_DATA_RD) |=> x_rdata == ZERO_WORD;
   endproperty
   a_inv_zero: assert property (p_inv_zero) else $error("invalid not zero"); // [RL20]

   property p_win_dual_y;
      accept && win_hit && is_dual && !y_inv |=> !ymem_rd ##1 ymem_rd ##1 !ymem_rd;
   endproperty
   a_win_dual_y: assert property (p_win_dual_y) else $error("window Y fetch"); // [RL16]

   c_win_read: cover property (accept && win_hit);
   c_dual_read: cover property (accept && is_dual && !y_inv);
   c_tbl_write_hi: cover property (accept && (req_op == OP_TBL_WR_HI));
endmodule

// File: tb/mem_model.sv
`timescale 1ns/100ps
// ==========================================
// Program and data memories behind the block
module mem_model (
   input wire logic clk,
   input wire logic [23:0] pm_addr,
   input wire logic pm_rd,
   input wire logic [15:0] xmem_addr,
   input wire logic xmem_rd,
   input wire logic [15:0] ymem_addr,
   input wire logic ymem_rd,
   output logic [23:0] pm_rdata,
   output logic [15:0] xmem_rdata,
   output logic [15:0] ymem_rdata
);
   // Data valid the cycle after a strobe, inverted last value otherwise
   always @(posedge clk) begin
      pm_rdata <= pm_rd ? {pm_addr[7:0], pm_addr[15:0] ^ 16'h5A5A} : ~pm_rdata;
      xmem_rdata <= xmem_rd ? xmem_addr ^ 16'hC3C3 : ~xmem_rdata;
      ymem_rdata <= ymem_rd ? ymem_addr ^ 16'h0F0F : ~ymem_rdata;
   end
endmodule

// File: tb/test_program_data_space_access.sv
`timescale 1ns/100ps
// ==========================================
// Testbench
module test_program_data_space_access;
   import program_data_space_access_pkg::*;
   logic clk, rstn, req_valid, req_byte, req_bitrev, req_modulo, x_ptr_sel, y_ptr_sel;
   logic in_repeat, repeat_first, repeat_last, repeat_int_exit, repeat_reentry;
   logic program_window_enable, req_ready, pm_rd, pm_wr, pm_config_space, xmem_rd, xmem_wr;
   logic ymem_rd, rsp_valid, bitrev_ok, modulo_ok, xw, pw, pcfg;
   op_t req_op;
   instr_cls_t req_cls;
   logic [15:0] req_ea, req_wdata, x_pointer_a, x_pointer_b, y_pointer_a, y_pointer_b;
   logic [15:0] xmem_addr, xmem_wdata, xmem_rdata, ymem_addr, ymem_rdata, x_rdata, y_rdata;
   logic [15:0] xa, xd, xr, yr, e16;
   logic [7:0] program_window_page, table_page_reg;
   logic [23:0] pm_addr, pm_wdata, pm_rdata, pa, pwd, w;
   logic [2:0] pm_be, pbe;
   logic [1:0] xmem_be, extra_cycles, xb, ex;
   int lat, npr, error_cnt, cmp_count;

   program_data_space_access DUT (.*);
   mem_model mem (.*);

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function automatic logic [23:0] pwf(input logic [23:0] a);
      return {a[7:0], a[15:0] ^ 16'h5A5A};
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic finish_test();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ==========================================
   // One request, entered and left at a falling edge
   task automatic do_req(input op_t op, input logic byt, input logic [15:0] ea,
                         input logic [15:0] wd);
      req_op = op;
      req_byte = byt;
      req_ea = ea;
      req_wdata = wd;
      req_valid = 1'b1;
      @(posedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      lat = 1;
      npr = 0;
      xw = 1'b0;
      pw = 1'b0;
      while (rsp_valid !== 1'b1 && lat < 10) begin
         if (pm_rd === 1'b1) npr++;
         if (pm_rd === 1'b1 || pm_wr === 1'b1) begin
            pa = pm_addr;
            pcfg = pm_config_space;
            pbe = pm_be;
            pwd = pm_wdata;
         end
         if (pm_wr === 1'b1) pw = 1'b1;
         if (xmem_wr === 1'b1) begin
            xw = 1'b1;
            xa = xmem_addr;
            xb = xmem_be;
            xd = xmem_wdata;
         end
         @(negedge clk);
         lat++;
      end
      if (rsp_valid !== 1'b1) begin
         error_cnt++;
         $display("mismatch %0t: no response", $time);
      end
      xr = x_rdata;
      yr = y_rdata;
      ex = extra_cycles;
   endtask

   // ==========================================
   // Scenarios
   task automatic t_table_read();
      table_page_reg = 8'h81;
      program_window_enable = 1'b1;
      for (int i = 0; i < 6; i++) begin
         do_req(i < 3 ? OP_TBL_RD_LO : OP_TBL_RD_HI, i % 3 != 0,
                16'h8020 + 16'(i % 3) - 16'h0001, 0);
         w = pwf({table_page_reg, req_ea});
         if (i < 3) e16 = i == 0 ? w[15:0] : {8'h00, i == 1 ? w[7:0] : w[15:8]};
         else e16 = i == 4 ? {8'h00, w[23:16]} : 16'h0000;
         if (i == 3) e16 = {8'h00, w[23:16]};
         chk(xr, e16, "table rd");
         chk(pa, {table_page_reg, req_ea}, "table addr");
         chk({pcfg, lat[3:0]}, {1'b1, 4'h3}, "cfg lat");
      end
   endtask

   task automatic t_window();
      program_window_page = 8'h03;
      in_repeat = 1'b0;
      for (int c = 0; c < 4; c++) begin
         req_cls = instr_cls_t'(c);
         do_req(OP_DATA_RD, 1'b0, 16'h8010, 0);
         chk(pa, 24'h01_8010, "win addr");
         chk(xr, pwf(24'h01_8010) & 24'h00_FFFF, "win data");
         chk({npr[3:0], lat[3:0]}, 8'h24, "win fetch");
         chk(ex, c == 3 ? EXTRA_TWO : EXTRA_ONE, "extra");
      end
      in_repeat = 1'b1;
      for (int k = 0; k < 5; k++) begin
         {repeat_first, repeat_last, repeat_int_exit, repeat_reentry} = 4'h8 >> (4 - k);
         do_req(OP_DATA_RD, 1'b0, 16'h8010, 0);
         chk(ex, k == 0 ? EXTRA_NONE : EXTRA_TWO, "rep extra");
      end
      in_repeat = 1'b0;
      {repeat_first, repeat_last, repeat_int_exit, repeat_reentry} = 4'h0;
      program_window_enable = 1'b0;
      do_req(OP_DATA_RD, 1'b0, 16'h8010, 0);
      chk({npr[3:0], xr}, 20'h0_0000, "win off");
      do_req(OP_DATA_RD, 1'b0, 16'h1200, 0);
      chk({ex, xr}, {EXTRA_NONE, 16'h1200 ^ 16'hC3C3}, "y via x");
      do_req(OP_DATA_RD, 1'b1, 16'h0101, 0);
      chk(xr, 16'h00C2, "byte rd");
   endtask

   task automatic t_dual();
      x_pointer_a = 16'h0100;
      x_pointer_b = 16'h1100;
      y_pointer_a = 16'h1200;
      y_pointer_b = 16'h0200;
      {x_ptr_sel, y_ptr_sel} = 2'b00;
      do_req(OP_DUAL_RD, 1'b0, 16'h0000, 0);
      chk({xr, yr}, {16'h0100 ^ 16'hC3C3, 16'h1200 ^ 16'h0F0F}, "dual");
      {x_ptr_sel, y_ptr_sel} = 2'b11;
      do_req(OP_DUAL_RD, 1'b0, 16'h0000, 0);
      chk({xr, yr}, 32'h0000_0000, "dual bad");
      program_window_enable = 1'b1;
      x_pointer_a = 16'h8010;
      {x_ptr_sel, y_ptr_sel} = 2'b00;
      do_req(OP_DUAL_RD, 1'b0, 16'h0000, 0);
      chk({xr, yr, lat[3:0]}, {16'hDA4A, 16'h1200 ^ 16'h0F0F, 4'h4}, "dual win");
   endtask

   task automatic t_write();
      req_bitrev = 1'b1;
      req_modulo = 1'b1;
      do_req(OP_DATA_WR, 1'b0, 16'h1F10, 16'h1234);
      chk({xw, pw, xa, xb, xd}, {2'b10, 16'h1F10, 2'h3, 16'h1234}, "wr");
      chk({bitrev_ok, modulo_ok, lat[3:0]}, 6'h32, "modes");
      do_req(OP_DATA_RD, 1'b0, 16'h0100, 0);
      chk({bitrev_ok, modulo_ok}, 2'b01, "modes rd");
      req_bitrev = 1'b0;
      req_modulo = 1'b0;
      do_req(OP_DATA_WR, 1'b1, 16'h0011, 16'h00AB);
      chk({xw, xb, xd, bitrev_ok}, {1'b1, BE_HIGH, 16'hABAB, 1'b0}, "byte wr");
      program_window_enable = 1'b1;
      do_req(OP_DATA_WR, 1'b0, 16'h9000, 16'h5555);
      chk({xw, pw}, 2'b00, "wr high");
      do_req(OP_TBL_WR_HI, 1'b1, 16'h0040, 16'h00CD);
      chk({pw, pbe, pwd}, {1'b1, PBE_B2, 24'hCD_0000}, "tbl wr hi");
      do_req(OP_TBL_WR_LO, 1'b0, 16'h0042, 16'hBEEF);
      chk({pw, pbe, pwd, pa}, {1'b1, PBE_LOW_WORD, 24'h00_BEEF, 24'h81_0042}, "tbl wr lo");
   endtask

   initial begin
      #(20 * 3000);
      error_cnt++;
      finish_test();
   end

   initial begin
      error_cnt = 0;
      cmp_count = 0;
      {rstn, req_valid, req_byte, req_bitrev, req_modulo, x_ptr_sel, y_ptr_sel} = 0;
      {in_repeat, repeat_first, repeat_last, repeat_int_exit, repeat_reentry} = 0;
      {program_window_enable, program_window_page, table_page_reg} = 0;
      {req_ea, req_wdata, x_pointer_a, x_pointer_b, y_pointer_a, y_pointer_b} = 0;
      req_op = OP_DATA_RD;
      req_cls = CLS_OTHER;
      repeat (12) @(negedge clk);
      chk({req_ready, rsp_valid, pm_rd, x_rdata}, {3'b100, 16'h0000}, "reset");
      rstn = 1'b1;
      t_table_read();
      t_window();
      t_dual();
      t_write();
      finish_test();
   end
endmodule
